// ===== core/dfw_core.sv
// Communication trips, warnings and output routing of the drive supervisor.
// Assumes all detector inputs are synchronous to clk and an Avalon-MM master.
`timescale 1ns/100ps
`default_nettype none
module dfw_core
    import dfw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter int unsigned IO_TRIP_TKS = IO_TRIP_TICKS
)(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [AW-1:0]    avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    input  wire logic             inverter_running,
    input  wire logic             cmd_from_keypad,
    input  wire logic             freq_cmd_fault,
    input  wire logic             run_cmd_fault,
    input  wire logic             p2p_unsuitable,
    input  wire logic             io_board_absent,
    input  wire logic             io_board_poor_link,
    input  wire logic             comm_card_absent,
    input  wire logic             comm_card_poor_link,
    input  wire logic             param_write_busy,
    input  wire logic             keypad_comm_fail,
    input  wire logic             option_fitted,
    input  wire logic             option_comm_err,
    input  wire logic             motor_overload_det,
    input  wire logic             motor_underload_det,
    input  wire logic [VAL_W-1:0] iol_accum,
    input  wire logic [VAL_W-1:0] inverter_thermal_overload,
    input  wire logic             fan_fault_det,
    input  wire logic [VAL_W-1:0] fan_usage_value,
    input  wire logic [VAL_W-1:0] cap_measured_value,
    input  wire logic [VAL_W-1:0] brake_usage_rate,
    input  wire logic [VAL_W-1:0] rotor_time_constant,
    output logic                  lost_cmd_trip,
    output logic                  io_board_trip,
    output logic                  param_write_trip,
    output logic                  option_trip,
    output logic                  io_link_fault,
    output logic                  overload_warn,
    output logic                  underload_warn,
    output logic                  inverter_overload_prewarn,
    output logic                  lost_cmd_warn,
    output logic                  fan_warn,
    output logic                  fan_replace_alarm,
    output logic                  cap_replace_alarm,
    output logic                  brake_duty_warn,
    output logic                  tr_tune_warn,
    output logic                  dout1,
    output logic                  relay_out
);
    localparam int unsigned TCW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam int unsigned PW  = VAL_W + 7;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction

    // Any code that names no warning leaves the output off.
    function automatic logic fn_pick(input logic [7:0]    code,
                                     input logic [NW-1:0] w);
        case (code)
            FN_OVL:  return w[W_OVL];
            FN_IOL:  return w[W_IOL];
            FN_UDL:  return w[W_UDL];
            FN_FANW: return w[W_FNW];
            FN_LCW:  return w[W_LCW];
            FN_CAPX: return w[W_CPX];
            FN_FANX: return w[W_FNX];
            default: return 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    logic [TCW-1:0] tick_cnt_q;
    logic [TCW-1:0] tick_cnt_d;
    logic           tick_q;
    logic           tick_d;

    always_comb
    begin
        tick_d     = 1'b0;
        tick_cnt_d = tick_cnt_q + 1'b1;
        if (tick_cnt_q == TCW'(TICK_CYCLES - 1))
        begin
            tick_cnt_d = '0;
            tick_d     = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    dfw_bus_t    bus_q;
    dfw_bus_t    bus_d;
    logic [31:0] sel_q, sel_d;
    logic [31:0] outfn_q, outfn_d;
    logic [31:0] thr0_q, thr0_d;
    logic [31:0] thr1_q, thr1_d;
    logic [31:0] trlim_q, trlim_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] rd_mux;
    logic [31:0] status;
    logic        wr_en;
    logic [NT-1:0] clr_mask;
    logic [NT-1:0] trip_q, trip_d, trip_set;
    logic [NW-1:0] warn_q, warn_d;
    logic        io_fault_q, io_fault_d;
    logic        io_expired;
    logic        dout1_q, dout1_d, relay_q, relay_d;

    // Each access takes one wait cycle so read data always come from a flop.
    assign avs_waitrequest = (avs_read || avs_write) && (bus_q != BUS_ACK);
    assign wr_en    = (bus_q == BUS_ACK) && avs_write;
    assign clr_mask = (wr_en && avs_address == A_TRCLR) ? avs_writedata[NT-1:0] : '0;
    assign status   = {15'h0000, warn_q, 3'h0, io_fault_q, trip_q};

    always_comb
    begin
        case (avs_address)
            A_SEL:   rd_mux = sel_q;
            A_OUTFN: rd_mux = outfn_q;
            A_THR0:  rd_mux = thr0_q;
            A_THR1:  rd_mux = thr1_q;
            A_TRLIM: rd_mux = trlim_q;
            A_STAT:  rd_mux = status;
            default: rd_mux = REG_RST;
        endcase
    end

    always_comb
    begin
        bus_d   = bus_q;
        rdata_d = rdata_q;
        sel_d   = sel_q;
        outfn_d = outfn_q;
        thr0_d  = thr0_q;
        thr1_d  = thr1_q;
        trlim_d = trlim_q;
        unique case (bus_q)
            BUS_IDLE:
            begin
                if (avs_read || avs_write)
                    bus_d = BUS_ACK;
                if (avs_read)
                    rdata_d = rd_mux;
            end
            BUS_ACK:
                bus_d = BUS_IDLE;
            default:
                bus_d = BUS_IDLE;
        endcase
        if (wr_en)
        begin
            case (avs_address)
                A_SEL:   sel_d   = be_merge(sel_q, avs_writedata, avs_byteenable);
                A_OUTFN: outfn_d = be_merge(outfn_q, avs_writedata, avs_byteenable);
                A_THR0:  thr0_d  = be_merge(thr0_q, avs_writedata, avs_byteenable);
                A_THR1:  thr1_d  = be_merge(thr1_q, avs_writedata, avs_byteenable);
                A_TRLIM: trlim_d = be_merge(trlim_q, avs_writedata, avs_byteenable);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bus_q   <= BUS_IDLE;
            rdata_q <= REG_RST;
            sel_q   <= REG_RST;
            outfn_q <= REG_RST;
            thr0_q  <= REG_RST;
            thr1_q  <= REG_RST;
            trlim_q <= REG_RST;
        end
        else
        begin
            bus_q   <= bus_d;
            rdata_q <= rdata_d;
            sel_q   <= sel_d;
            outfn_q <= outfn_d;
            thr0_q  <= thr0_d;
            thr1_q  <= thr1_d;
            trlim_q <= trlim_d;
        end
    end

    assign avs_readdata = rdata_q;

    // ------------------------------------------------------------
    // Trips and warnings
    // ------------------------------------------------------------
    logic [SEL_W-1:0] lc_sel, lc_cfg, ovl_sel, udl_sel, fan_mode, cap_mode, ctrl_mode;
    logic [VAL_W-1:0] fan_thr, db_lvl, cap_thr, tr_lo, tr_hi;
    logic             lc_cond;
    logic [PW-1:0]    iol_lhs, iol_rhs;

    assign lc_sel    = sel_q[L_LC_SEL +: SEL_W];
    assign lc_cfg    = sel_q[L_LC_CFG +: SEL_W];
    assign ovl_sel   = sel_q[L_OVL +: SEL_W];
    assign udl_sel   = sel_q[L_UDL +: SEL_W];
    assign fan_mode  = sel_q[L_FANM +: SEL_W];
    assign cap_mode  = sel_q[L_CAPM +: SEL_W];
    assign ctrl_mode = sel_q[L_CTRL +: SEL_W];
    assign fan_thr   = thr0_q[L_LO +: VAL_W];
    assign db_lvl    = thr0_q[L_HI +: VAL_W];
    assign cap_thr   = thr1_q[L_LO +: VAL_W];
    assign tr_lo     = trlim_q[L_LO +: VAL_W];
    assign tr_hi     = trlim_q[L_HI +: VAL_W];
    assign lc_cond   = inverter_running && !cmd_from_keypad
                       && (freq_cmd_fault || run_cmd_fault);
    assign iol_lhs   = PW'(iol_accum) * PW'(PCT_FULL);
    assign iol_rhs   = PW'(inverter_thermal_overload) * PW'(IOL_PCT);

    dfw_persist #(
        .LIMIT   (IO_TRIP_TKS)
    ) u_io_persist (
        .clk     (clk),
        .rst_n   (rst_n),
        .tick    (tick_q),
        .cond    (io_fault_q),
        .expired (io_expired)
    );

    always_comb
    begin
        io_fault_d = io_board_absent || io_board_poor_link
                     || comm_card_absent || comm_card_poor_link;
        trip_set        = '0;
        trip_set[T_LC]  = lc_cond && (lc_sel != LC_OFF);
        trip_set[T_IO]  = io_expired;
        trip_set[T_PAR] = param_write_busy && keypad_comm_fail;
        trip_set[T_OPT] = option_fitted && option_comm_err;
        // A new trip in the clearing cycle wins over the clear.
        trip_d = trip_set | (trip_q & LATCH_MASK & ~clr_mask);
        warn_d        = '0;
        warn_d[W_OVL] = motor_overload_det && (ovl_sel == OVL_ON);
        warn_d[W_UDL] = motor_underload_det && (udl_sel == UDL_ON);
        warn_d[W_IOL] = (iol_lhs >= iol_rhs);
        warn_d[W_LCW] = (lc_cond && (lc_cfg != LC_OFF))
                        || p2p_unsuitable;
        warn_d[W_FNW] = fan_fault_det && (fan_mode == FANW_ON);
        warn_d[W_FNX] = fan_usage_value < fan_thr;
        warn_d[W_CPX] = (cap_measured_value < cap_thr)
                        && (cap_mode == CAP_PREDIAG);
        warn_d[W_DBW] = brake_usage_rate > db_lvl;
        warn_d[W_TRW] = (ctrl_mode == CTRL_TR)
                        && ((rotor_time_constant < tr_lo) || (rotor_time_constant > tr_hi));
        dout1_d = fn_pick(outfn_q[L_FN1 +: 8], warn_q);
        relay_d = fn_pick(outfn_q[L_FNR +: 8], warn_q);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            io_fault_q <= 1'b0;
            trip_q     <= '0;
            warn_q     <= '0;
            dout1_q    <= 1'b0;
            relay_q    <= 1'b0;
        end
        else
        begin
            io_fault_q <= io_fault_d;
            trip_q     <= trip_d;
            warn_q     <= warn_d;
            dout1_q    <= dout1_d;
            relay_q    <= relay_d;
        end
    end

    assign lost_cmd_trip             = trip_q[T_LC];
    assign io_board_trip             = trip_q[T_IO];
    assign param_write_trip          = trip_q[T_PAR];
    assign option_trip               = trip_q[T_OPT];
    assign io_link_fault             = io_fault_q;
    assign overload_warn             = warn_q[W_OVL];
    assign underload_warn            = warn_q[W_UDL];
    assign inverter_overload_prewarn = warn_q[W_IOL];
    assign lost_cmd_warn             = warn_q[W_LCW];
    assign fan_warn                  = warn_q[W_FNW];
    assign fan_replace_alarm         = warn_q[W_FNX];
    assign cap_replace_alarm         = warn_q[W_CPX];
    assign brake_duty_warn           = warn_q[W_DBW];
    assign tr_tune_warn              = warn_q[W_TRW];
    assign dout1                     = dout1_q;
    assign relay_out                 = relay_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    lc_trip_a: assert property (##1 lost_cmd_trip ==
        $past(lc_cond && lc_sel != LC_OFF)) else $error("lost command trip off its cause");
    io_trip_a: assert property ($rose(io_board_trip) |->
        $past(io_expired) && $past(io_fault_q, 2)) else $error("io trip without lasting fault");
    io_fault_a: assert property (##1 io_link_fault == $past(io_board_absent
        || io_board_poor_link || comm_card_absent || comm_card_poor_link))
        else $error("link fault flag does not follow board presence");
    par_trip_a: assert property (param_write_busy && keypad_comm_fail
        |=> param_write_trip) else $error("parameter write trip missed");
    opt_trip_a: assert property ($rose(option_trip) |->
        $past(option_fitted && option_comm_err)) else $error("option trip without card error");
    ovl_warn_a: assert property (overload_warn |->
        $past(ovl_sel == OVL_ON && motor_overload_det)) else $error("overload warn unselected");
    out_route_a: assert property (outfn_q[L_FNR +: 8] == FN_UDL && $stable(outfn_q)
        |=> relay_out == $past(underload_warn)) else $error("relay misses underload warning");
    lc_warn_a: assert property (p2p_unsuitable |=> lost_cmd_warn)
        else $error("lost command warning missed on unsuitable peer link");
    cap_alarm_a: assert property (cap_replace_alarm |->
        $past(cap_mode) == CAP_PREDIAG) else $error("capacitor alarm outside diagnosis mode");
    trip_hold_a: assert property (param_write_trip && clr_mask[T_PAR] == 1'b0
        |=> param_write_trip) else $error("latched trip dropped without a clear");

    io_trip_c: cover property ($rose(io_board_trip));
    lc_trip_c: cover property ($rose(lost_cmd_trip) ##[1:20] $fell(lost_cmd_trip));
    relay_c:   cover property ($rose(relay_out));
    clear_c:   cover property (param_write_trip ##1 !param_write_trip);
endmodule
`default_nettype wire

// ===== core/dfw_pkg.sv
// Constants, bus states and register map of the drive fault and warning supervisor.
// Assumes a single 50 MHz clock and an Avalon-MM master that holds each request.
`default_nettype none
package dfw_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned TICK_MS       = 1;
    localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned IO_TRIP_S     = 5;
    localparam int unsigned IO_TRIP_TICKS = IO_TRIP_S * 1000 / TICK_MS;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned AW      = 5;
    localparam logic [4:0]  A_SEL   = 5'h00;
    localparam logic [4:0]  A_OUTFN = 5'h04;
    localparam logic [4:0]  A_THR0  = 5'h08;
    localparam logic [4:0]  A_THR1  = 5'h0C;
    localparam logic [4:0]  A_TRLIM = 5'h10;
    localparam logic [4:0]  A_STAT  = 5'h14;
    localparam logic [4:0]  A_TRCLR = 5'h18;
    localparam logic [31:0] REG_RST = 32'h0000_0000;

    // Selection nibbles inside the selection register, then threshold halfword and output function byte fields.
    localparam int unsigned SEL_W    = 4;
    localparam int unsigned L_LC_SEL = 0;
    localparam int unsigned L_LC_CFG = 4;
    localparam int unsigned L_OVL    = 8;
    localparam int unsigned L_UDL    = 12;
    localparam int unsigned L_FANM   = 16;
    localparam int unsigned L_CAPM   = 20;
    localparam int unsigned L_CTRL   = 24;
    localparam int unsigned VAL_W    = 16;
    localparam int unsigned L_LO     = 0;
    localparam int unsigned L_HI     = 16;
    localparam int unsigned L_FN1    = 0;
    localparam int unsigned L_FNR    = 8;

    localparam logic [3:0] LC_OFF      = 4'h0;
    localparam logic [3:0] OVL_ON      = 4'h1;
    localparam logic [3:0] UDL_ON      = 4'h1;
    localparam logic [3:0] FANW_ON     = 4'h1;
    localparam logic [3:0] CAP_PREDIAG = 4'h2;
    localparam logic [3:0] CTRL_TR     = 4'h4;
    localparam int unsigned IOL_PCT    = 60;
    localparam int unsigned PCT_FULL   = 100;

    // Output function codes.
    localparam logic [7:0] FN_OVL  = 8'h05;
    localparam logic [7:0] FN_IOL  = 8'h06;
    localparam logic [7:0] FN_UDL  = 8'h07;
    localparam logic [7:0] FN_FANW = 8'h08;
    localparam logic [7:0] FN_LCW  = 8'h0D;
    localparam logic [7:0] FN_CAPX = 8'h24;
    localparam logic [7:0] FN_FANX = 8'h26;

    // Trip and warning bit positions.
    localparam int unsigned NT    = 4;
    localparam int unsigned T_LC  = 0;
    localparam int unsigned T_IO  = 1;
    localparam int unsigned T_PAR = 2;
    localparam int unsigned T_OPT = 3;
    localparam logic [3:0] LATCH_MASK = 4'hE;
    localparam int unsigned NW    = 9;
    localparam int unsigned W_OVL = 0;
    localparam int unsigned W_UDL = 1;
    localparam int unsigned W_IOL = 2;
    localparam int unsigned W_LCW = 3;
    localparam int unsigned W_FNW = 4;
    localparam int unsigned W_FNX = 5;
    localparam int unsigned W_CPX = 6;
    localparam int unsigned W_DBW = 7;
    localparam int unsigned W_TRW = 8;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } dfw_bus_t;
endpackage
`default_nettype wire

// ===== core/dfw_persist.sv
// Persistence timer: reports a condition that has held past a tick limit.
// Assumes tick is a one-cycle enable pulse from a divider on the same clock.
`timescale 1ns/100ps
`default_nettype none
module dfw_persist
    import dfw_pkg::*;
#(
    parameter int unsigned LIMIT = IO_TRIP_TICKS
)(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic tick,
    input  wire logic cond,
    output logic      expired
);
    localparam int unsigned CW = $clog2(LIMIT + 2);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          exp_q;
    logic          exp_d;

    // Any gap in the condition restarts the count, so only an unbroken run expires.
    always_comb
    begin
        cnt_d = cnt_q;
        if (!cond)
            cnt_d = '0;
        else if (tick && (cnt_q <= CW'(LIMIT)))
            cnt_d = cnt_q + 1'b1;
        exp_d = cond && (cnt_q > CW'(LIMIT));
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign expired = exp_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    persist_cause_a: assert property (exp_q |->
        $past(cond) && $past(cnt_q) > CW'(LIMIT)) else $error("expiry without unbroken run");
endmodule
`default_nettype wire

// ===== test/dfw_far_side.sv
// Far-side model: I/O board, option card and keypad link status.
// Assumes the bench picks the fault; status lags it by one edge.
`timescale 1ns/100ps
`default_nettype none
module dfw_far_side (
    input  wire logic       clk,
    input  wire logic [2:0] io_mode,
    input  wire logic       kp_fail,
    input  wire logic       opt_in,
    input  wire logic       opt_err,
    output logic            io_board_absent,
    output logic            io_board_poor_link,
    output logic            comm_card_absent,
    output logic            comm_card_poor_link,
    output logic            keypad_comm_fail,
    output logic            option_fitted,
    output logic            option_comm_err
);
    // Registered so the block sees a real board's lag rather than the bench.
    always @(posedge clk)
    begin
        io_board_absent     <= io_mode == 3'h1;
        io_board_poor_link  <= io_mode == 3'h2;
        comm_card_absent    <= io_mode == 3'h3;
        comm_card_poor_link <= io_mode == 3'h4;
        keypad_comm_fail    <= kp_fail;
        option_fitted       <= opt_in;
        option_comm_err     <= opt_err;
    end
endmodule
`default_nettype wire

// ===== test/drive_fault_warning_supervisor_bench.sv
// Bench for the supervisor core with the far-side model attached.
// Assumes short tick settings: 4 cycles a tick, trip after more than 3 ticks.
`timescale 1ns/100ps
`default_nettype none
module drive_fault_warning_supervisor_bench;
    import dfw_pkg::*;
    logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [AW-1:0] avs_address = 5'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, r;
    logic [3:0] avs_byteenable = 4'hF;
    logic inverter_running = 0, cmd_from_keypad = 0, freq_cmd_fault = 0, run_cmd_fault = 0;
    logic p2p_unsuitable = 0, param_write_busy = 0, motor_overload_det = 0;
    logic motor_underload_det = 0, fan_fault_det = 0, kp_fail = 0, opt_in = 0, opt_err = 0;
    logic [2:0] io_mode = 3'h0;
    logic [VAL_W-1:0] iol_accum = '0, inverter_thermal_overload = '0, fan_usage_value = '0;
    logic [VAL_W-1:0] cap_measured_value = '0, brake_usage_rate = '0, rotor_time_constant = '0;
    logic io_board_absent, io_board_poor_link, comm_card_absent, comm_card_poor_link;
    logic keypad_comm_fail, option_fitted, option_comm_err, lost_cmd_trip, io_board_trip;
    logic param_write_trip, option_trip, io_link_fault, overload_warn, underload_warn;
    logic inverter_overload_prewarn, lost_cmd_warn, fan_warn, fan_replace_alarm;
    logic cap_replace_alarm, brake_duty_warn, tr_tune_warn, dout1, relay_out;
    int fails = 0, num_checks = 0;
    always #10 clk = ~clk;
    dfw_core #(.TICK_CYCLES(4), .IO_TRIP_TKS(3)) dut (.*);
    dfw_far_side far (.*);
    task cy(input int n); repeat (n) @(posedge clk); endtask
    task ck(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // Request is held until waitrequest is seen low at an edge.
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a; avs_writedata <= d; avs_write <= w; avs_read <= !w;
        @(posedge clk);
        while (avs_waitrequest !== 1'h0)
            @(posedge clk);
        r = avs_readdata;
        avs_write <= 0; avs_read <= 0;
        cy(3);
    endtask
    task results;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task t_regs;
        bus(0, A_STAT, 32'h0);
        ck("status reset", 32'h0000_0400, r);
        bus(0, 5'h1C, 32'h0);
        ck("unmapped", 32'h0, r);
        $display("register test done");
    endtask
    task t_lc;
        bus(1, A_SEL, 32'h0421_1111);
        inverter_running <= 1; freq_cmd_fault <= 1; cy(3);
        ck("lc trip", 1'h1, lost_cmd_trip);
        ck("lc warn", 1'h1, lost_cmd_warn);
        cmd_from_keypad <= 1; cy(3);
        ck("lc keypad", 1'h0, lost_cmd_trip);
        cmd_from_keypad <= 0; freq_cmd_fault <= 0; run_cmd_fault <= 1;
        bus(1, A_SEL, 32'h0421_1110);
        ck("lc off", 1'h0, lost_cmd_trip);
        ck("lc warn sel0", 1'h1, lost_cmd_warn);
        run_cmd_fault <= 0; p2p_unsuitable <= 1; cy(3);
        ck("p2p warn", 1'h1, lost_cmd_warn);
        p2p_unsuitable <= 0;
        $display("lost command test done");
    endtask
    task t_io;
        for (int i = 1; i < 5; i++)
        begin
            io_mode <= 3'(i); cy(4);
            ck("link fault", 1'h1, io_link_fault);
            io_mode <= 0; cy(4);
        end
        io_mode <= 1; cy(10);
        ck("io early", 1'h0, io_board_trip);
        cy(20);
        ck("io trip", 1'h1, io_board_trip);
        io_mode <= 0; cy(4);
        ck("io held", 1'h1, io_board_trip);
        bus(1, A_TRCLR, 32'h2);
        ck("io clear", 1'h0, io_board_trip);
        $display("io board test done");
    endtask
    task t_par_opt;
        kp_fail <= 1; opt_err <= 1; cy(4);
        ck("par idle", 1'h0, param_write_trip);
        ck("opt unfitted", 1'h0, option_trip);
        param_write_busy <= 1; opt_in <= 1; cy(4);
        ck("par trip", 1'h1, param_write_trip);
        ck("opt trip", 1'h1, option_trip);
        kp_fail <= 0; opt_err <= 0; param_write_busy <= 0;
        bus(1, A_TRCLR, 32'hC);
        ck("par opt clear", 2'h0, {param_write_trip, option_trip});
        $display("param and option test done");
    endtask
    task t_warn;
        motor_overload_det <= 1;
        bus(1, A_OUTFN, 32'h0705);
        ck("ovl dout", 2'h3, {overload_warn, dout1});
        ck("udl relay", 1'h0, relay_out);
        motor_underload_det <= 1; cy(3);
        ck("udl relay on", 2'h3, {underload_warn, relay_out});
        iol_accum <= 16'h3C; inverter_thermal_overload <= 16'h64; fan_fault_det <= 1;
        bus(1, A_OUTFN, 32'h0D06);
        ck("iol dout", 2'h3, {inverter_overload_prewarn, dout1});
        ck("lcw relay", 1'h0, relay_out);
        ck("fan warn", 1'h1, fan_warn);
        iol_accum <= 16'h3B; fan_usage_value <= 16'hF; brake_usage_rate <= 16'h51;
        cap_measured_value <= 16'h1F; rotor_time_constant <= 16'hFF;
        bus(1, A_THR0, 32'h0050_0010);
        bus(1, A_THR1, 32'h20);
        bus(1, A_TRLIM, 32'h0200_0100);
        ck("iol low", 1'h0, inverter_overload_prewarn);
        ck("brake", 1'h1, brake_duty_warn);
        ck("tr low", 1'h1, tr_tune_warn);
        rotor_time_constant <= 16'h250;
        bus(1, A_OUTFN, 32'h2624);
        ck("cap fan out", 4'hF, {cap_replace_alarm, dout1, fan_replace_alarm,
            relay_out});
        ck("fan replace", 1'h1, fan_replace_alarm);
        ck("tr high", 1'h1, tr_tune_warn);
        bus(1, A_OUTFN, 32'h0008);
        ck("fan dout", 3'h6, {fan_warn, dout1, relay_out});
        brake_usage_rate <= 16'h50; rotor_time_constant <= 16'h150;
        bus(1, A_SEL, 32'h0);
        ck("modes off", 6'h0, {brake_duty_warn, tr_tune_warn, cap_replace_alarm, fan_warn,
            overload_warn, underload_warn});
        $display("warning test done");
    endtask
    initial
    begin
        cy(6);
        rst_n <= 1;
        t_regs;
        t_lc;
        t_io;
        t_par_opt;
        t_warn;
        results;
    end
    initial
    begin
        #100000;
        fails++;
        results;
    end
endmodule
`default_nettype wire
